/* File: core/sss_defs.svh */
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH

// Operation select codes on the decode port
`define SSS_OP_NONE 3'h0
`define SSS_OP_SUB_ACC 3'h1
`define SSS_OP_SUB_MEM 3'h2
`define SSS_OP_SUB_IMM 3'h3
`define SSS_OP_SWAP_MEM 3'h4
`define SSS_OP_SWAP_ACC 3'h5
`define SSS_OP_SKIP_ZERO 3'h6

// Flag vector bit positions
`define SSS_FLAG_C 0
`define SSS_FLAG_AC 1
`define SSS_FLAG_Z 2
`define SSS_FLAG_OV 3

`define SSS_ACC_RESET 8'h00
`define SSS_FLAGS_RESET 4'h0
// Machine cycles of a taken skip
`define SSS_SKIP_CYCLES 2

`endif

/* File: core/sss_pkg.sv */
package sss_pkg;
  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic [7:0] imm;
  } sss_instr_t;

  typedef struct packed {
    logic we;
    logic [7:0] data;
  } sss_mem_wr_t;

  typedef struct packed {
    logic overflowFlag;
    logic zero;
    logic halfCarryFlag;
    logic carry;
  } sss_flags_t;
endpackage

/* File: core/sss_exec.sv */
// Behaviour
// [RULE1] Memory subtract into accumulator: acc + ~m + 1
// [RULE2] Same difference stored back to memory
// [RULE3] Immediate subtract into accumulator
// [RULE4] Swap nibbles of memory byte in place
// [RULE5] Swapped memory byte to accumulator only
// [RULE6] Zero byte discards prefetched instruction
// [RULE7] Taken skip lasts two cycles, else continue
// [RULE8] Subtracts set flags; swap and skip don't
`timescale 1ns/1ns
`include "sss_defs.svh"

module sss_exec #(
  parameter int DataWidth = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Decoded instruction and operand from data memory
  input sss_pkg::sss_instr_t instr,
  input wire logic [7:0] memData,
  // Data memory write-back
  output sss_pkg::sss_mem_wr_t memWr,
  // Pipeline control
  output logic discardNext,
  output logic busy,
  // Architectural state
  output logic [7:0] accumulator_reg,
  output sss_pkg::sss_flags_t flags
);

  localparam int NibbleWidth = DataWidth / 2;
  typedef enum logic {SssRun, SssDummy} sss_state_t;

  sss_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d;
  sss_pkg::sss_flags_t flags_q, flags_d;
  sss_pkg::sss_mem_wr_t memWr_q, memWr_d;
  // Copy of the discard strobe, kept only for the untaken-skip check
  logic discard_q;

  // Op compare shared by every decode line; codes 0 and 7 select nothing
  function automatic logic opIs(input logic [2:0] op, input logic [2:0] code);
    return op == code;
  endfunction

  // Accepted only outside the dummy cycle; an instruction offered then is dropped
  wire logic go = instr.valid && (state_q == SssRun);
  wire logic isSubAcc = go && opIs(instr.op, `SSS_OP_SUB_ACC);
  wire logic isSubMem = go && opIs(instr.op, `SSS_OP_SUB_MEM);
  wire logic isSubImm = go && opIs(instr.op, `SSS_OP_SUB_IMM);
  wire logic isSwapMem = go && opIs(instr.op, `SSS_OP_SWAP_MEM);
  wire logic isSwapAcc = go && opIs(instr.op, `SSS_OP_SWAP_ACC);
  wire logic isSkip = go && opIs(instr.op, `SSS_OP_SKIP_ZERO);
  wire logic isSub = isSubAcc || isSubMem || isSubImm;

  wire logic [7:0] subOperand = isSubImm ? instr.imm : memData; // [RULE3]
  wire logic [7:0] subInv = ~subOperand;
  // Low nibble sum kept separate so the half carry is the true nibble carry-out
  wire logic [4:0] lowSum = {1'b0, acc_q[3:0]} + {1'b0, subInv[3:0]} + 5'h01;
  wire logic [8:0] fullSum = {1'b0, acc_q} + {1'b0, subInv} + 9'h001; // [RULE1]
  wire logic [7:0] diff = fullSum[7:0];
  // Overflow needs unlike operand signs and a result sign that left the accumulator's
  wire logic subOv = (acc_q[7] != subOperand[7]) && (diff[7] != acc_q[7]);
  // Sign-extended difference, read only by the overflow cross-check
  wire logic [8:0] sgnDiff = {acc_q[7], acc_q} - {subOperand[7], subOperand};
  // Each result bit takes the bit half a word away, which exchanges the nibbles
  logic [DataWidth-1:0] swapped;
  for (genvar b = 0; b < DataWidth; b++) begin : g_swap
    assign swapped[b] = memData[(b + NibbleWidth) % DataWidth]; // [RULE4]
  end
  wire logic skipTaken = isSkip && (memData == 8'h00); // [RULE6]

  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    memWr_d = '{we: 1'b0, data: memWr_q.data};
    state_d = SssRun;
    if (isSubAcc || isSubImm) begin
      acc_d = diff; // [RULE1] [RULE3]
    end
    if (isSubMem) begin
      memWr_d = '{we: 1'b1, data: diff}; // [RULE2]
    end
    if (isSub) begin
      flags_d.carry = fullSum[8]; // [RULE8]
      flags_d.halfCarryFlag = lowSum[4];
      flags_d.zero = (diff == 8'h00);
      flags_d.overflowFlag = subOv;
    end
    if (isSwapMem) begin
      memWr_d = '{we: 1'b1, data: swapped}; // [RULE4]
    end
    if (isSwapAcc) begin
      acc_d = swapped; // [RULE5]
    end
    // The dummy cycle always hands back to run, so no code is illegal
    unique case (state_q)
      SssRun: begin
        if (skipTaken) begin
          state_d = SssDummy; // [RULE7]
        end
      end
      SssDummy: begin
        state_d = SssRun;
      end
    endcase
  end

  // Write-back is registered so memory sees one clean pulse the cycle after the op
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SssRun;
      acc_q <= `SSS_ACC_RESET;
      flags_q <= `SSS_FLAGS_RESET;
      memWr_q <= '0;
      discard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      memWr_q <= memWr_d;
      discard_q <= skipTaken;
    end
  end

  assign memWr = memWr_q;
  assign accumulator_reg = acc_q;
  assign flags = flags_q;
  // Discard is combinational so the prefetched word is dropped in the same cycle
  assign discardNext = skipTaken; // [RULE6]
  assign busy = (state_q == SssDummy); // [RULE7]

  // Assertions
  a_sub_acc_result: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
    isSubAcc |=> accumulator_reg == 8'($past(acc_q) - $past(memData)))
    else $error("Memory subtract to accumulator wrong");
  a_sub_mem_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    isSubMem |=> memWr.we && memWr.data == 8'($past(acc_q) - $past(memData)) && $stable(accumulator_reg))
    else $error("Memory subtract write-back wrong");
  a_sub_imm_result: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
    isSubImm |=> accumulator_reg == 8'($past(acc_q) - $past(instr.imm)))
    else $error("Immediate subtract wrong");
  a_swap_mem_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    isSwapMem |=> memWr.we && memWr.data[3:0] == $past(memData[7:4]) && memWr.data[7:4] == $past(memData[3:0]))
    else $error("In-place swap wrong");
  a_swap_acc_only: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    isSwapAcc |=> !memWr.we && accumulator_reg == {$past(memData[3:0]), $past(memData[7:4])})
    else $error("Swap to accumulator wrong");
  a_skip_discard: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    discardNext == (instr.valid && !busy && instr.op == `SSS_OP_SKIP_ZERO && memData == 8'h00))
    else $error("Discard does not match a zero byte skip");
  a_skip_two_cycles: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    skipTaken |=> busy ##1 !busy)
    else $error("Taken skip not two cycles");
  a_skip_not_taken: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    isSkip && memData != 8'h00 |=> !busy && !discard_q)
    else $error("Untaken skip stalled");
  a_flags_held: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    (isSwapMem || isSwapAcc || isSkip) |=> $stable(flags))
    else $error("Flags changed by swap or skip");
  a_sub_carry: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    isSubAcc |=> flags.carry == ($past(acc_q) >= $past(memData)) && flags.zero == (accumulator_reg == 8'h00))
    else $error("Subtract carry or zero wrong");

  // Flags: carry, half carry and overflow worked out from the operands rather than from the adder
  a_sub_imm_flags: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    isSubImm |=> flags.carry == ($past(acc_q) >= $past(instr.imm))
      && flags.zero == (accumulator_reg == 8'h00))
    else $error("Immediate subtract carry or zero wrong");
  a_sub_mem_flags: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    isSubMem |=> flags.carry == ($past(acc_q) >= $past(memData))
      && flags.zero == (memWr.data == 8'h00))
    else $error("Memory subtract carry or zero wrong");
  a_sub_half_carry: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    isSub |=> flags.halfCarryFlag == ($past(acc_q[3:0]) >= $past(subOperand[3:0])))
    else $error("Subtract half carry wrong");
  a_sub_overflow: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    isSub |=> flags.overflowFlag == ($past(sgnDiff[8]) != $past(sgnDiff[7])))
    else $error("Subtract overflow wrong");
  a_flags_change_cause: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    $changed(flags) |-> $past(isSub))
    else $error("Flags changed without a subtract");

  // Each variant writes only its own destination
  a_sub_no_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
    (isSubAcc || isSubImm) |=> !memWr.we)
    else $error("Accumulator subtract wrote memory");
  a_swap_keeps_acc: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    isSwapMem |=> $stable(accumulator_reg))
    else $error("In-place swap changed accumulator");
  a_swap_keeps_mem: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    isSwapAcc |=> $stable(memWr.data))
    else $error("Swap to accumulator changed write data");
  a_write_source: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    memWr.we |-> $past(isSubMem) || $past(isSwapMem))
    else $error("Memory write without a memory-destination op");
  a_acc_change_cause: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    $changed(accumulator_reg) |-> $past(isSubAcc) || $past(isSubImm) || $past(isSwapAcc))
    else $error("Accumulator changed without an accumulator op");

  // Skip and the dummy cycle
  a_skip_no_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    isSkip |=> !memWr.we && $stable(accumulator_reg))
    else $error("Skip changed memory or accumulator");
  a_untaken_no_discard: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    (isSkip && memData != 8'h00) |-> !discardNext)
    else $error("Nonzero byte discarded the next instruction");
  a_discard_once: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    discardNext |=> !discardNext)
    else $error("Discard held past the skip");
  a_busy_no_discard: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    busy |-> !discardNext)
    else $error("Discard raised in the dummy cycle");
  a_busy_ignores: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    busy |=> !busy && !memWr.we
      && $stable(accumulator_reg) && $stable(flags))
    else $error("Instruction taken in the dummy cycle");

  // Scenarios the bench is expected to reach
  c_skip_taken: cover property (@(posedge clk) disable iff (!resetn) skipTaken ##1 busy);
  c_sub_borrow: cover property (@(posedge clk) disable iff (!resetn) isSub ##1 !flags.carry);
  c_swap_mem: cover property (@(posedge clk) disable iff (!resetn) isSwapMem);
  c_sub_overflow: cover property (@(posedge clk) disable iff (!resetn) isSub ##1 flags.overflowFlag);
  c_swap_acc: cover property (@(posedge clk) disable iff (!resetn) isSwapAcc ##1 !memWr.we);

endmodule

/* File: sim/sss_mem_model.sv */
`timescale 1ns/1ns
module sss_mem_model (
  // Clock
  input wire logic clk,
  // Preload and core write-back
  input wire logic load,
  input wire logic [7:0] loadVal,
  input sss_pkg::sss_mem_wr_t memWr,
  // Operand
  output logic [7:0] memData
);
  always @(posedge clk) begin
    if (load) memData <= loadVal;
    else if (memWr.we) memData <= memWr.data;
  end
endmodule

/* File: sim/tb_sss_exec.sv */
`timescale 1ns/1ns
`include "sss_defs.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_sss_exec;
  logic clk = 0, resetn = 0, load = 0, discardNext, busy;
  logic [7:0] loadVal = 8'h00, memData, acc;
  sss_pkg::sss_instr_t instr = '0;
  sss_pkg::sss_mem_wr_t memWr;
  sss_pkg::sss_flags_t flags;
  int fails = 0, nTests = 0, cyc = 0;
  always #5 clk = ~clk;
  sss_exec dut (.clk(clk), .resetn(resetn), .instr(instr), .memData(memData), .memWr(memWr),
    .discardNext(discardNext), .busy(busy), .accumulator_reg(acc), .flags(flags));
  sss_mem_model mem (.clk(clk), .load(load), .loadVal(loadVal), .memWr(memWr), .memData(memData));
  task automatic test_done();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Preload the operand a cycle early, then issue one instruction
  task automatic run(input logic [2:0] op, input logic [7:0] m, imm);
    load = 1;
    loadVal = m;
    @(posedge clk);
    #1 load = 0;
    instr = {1'b1, op, imm};
    #1 `CHK("discard", (op == `SSS_OP_SKIP_ZERO && m == 8'h00), discardNext)
    @(posedge clk);
    #1 instr = '0;
  endtask
  task automatic t_arith();
    run(`SSS_OP_SWAP_ACC, 8'h73, 8'h00);
    `CHK("swapAcc", 8'h37, acc)
    `CHK("swapAccWe", 1'b0, memWr.we)
    `CHK("swapAccMem", 8'h73, memData)
    run(`SSS_OP_SUB_ACC, 8'h07, 8'h00);
    `CHK("subAcc", 8'h30, acc)
    `CHK("subAccFl", 4'h3, flags)
    run(`SSS_OP_SUB_IMM, 8'h55, 8'h30);
    `CHK("subImm", 8'h00, acc)
    `CHK("subImmFl", 4'h7, flags)
    run(`SSS_OP_SWAP_MEM, 8'ha5, 8'h00);
    `CHK("swapMem", 9'h15a, memWr)
    `CHK("swapMemFl", 4'h7, flags)
    // Let the write pulse reach the memory before the next preload
    @(posedge clk);
    #1 `CHK("swapMemLand", 8'h5a, memData)
    run(`SSS_OP_SUB_MEM, 8'h01, 8'h00);
    `CHK("subMem", 9'h1ff, memWr)
    `CHK("subMemAcc", 8'h00, acc)
    `CHK("subMemFl", 4'h0, flags)
    run(`SSS_OP_SWAP_ACC, 8'h08, 8'h00);
    run(`SSS_OP_SUB_IMM, 8'h00, 8'h01);
    `CHK("subOvf", 8'h7f, acc)
    `CHK("subOvfFl", 4'h9, flags)
  endtask
  task automatic t_skip();
    int len;
    run(`SSS_OP_SKIP_ZERO, 8'h04, 8'h00);
    `CHK("noSkip", 1'b0, busy)
    load = 1;
    loadVal = 8'h00;
    @(posedge clk);
    #1 load = 0;
    instr = {1'b1, `SSS_OP_SKIP_ZERO, 8'h00};
    #1 `CHK("skipTaken", 1'b1, discardNext)
    @(posedge clk);
    // Offered during the dummy cycle, so it must be dropped
    #1 instr = {1'b1, `SSS_OP_SUB_IMM, 8'h01};
    len = 1 + busy;
    `CHK("dummy", 1'b1, busy)
    @(posedge clk);
    #1 instr = '0;
    len = len + busy;
    `CHK("skipLen", `SSS_SKIP_CYCLES, len)
    `CHK("dummyEnd", 1'b0, busy)
    `CHK("dropped", 8'h7f, acc)
    `CHK("skipFl", 4'h9, flags)
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 200) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1;
    t_arith();
    t_skip();
    test_done();
  end
endmodule
